// File: rtl/battery_level_sampling.sv
`timescale 1ns/100ps

module battery_level_sampling
    import battery_level_pkg::*;
#(
    parameter int INSTR_CLKS = INSTR_CYCLE_CLKS
)(
    // Clock, reset, enable
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ce,
    // AHB-Lite slave
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    // Detector and timer
    input  wire logic        i_tick_2hz,
    input  wire logic        i_detect_result,
    input  wire logic        i_sub_low,
    output logic             o_detect_enable,
    output logic      [2:0]  o_threshold_select,
    // Interrupt
    output logic             o_irq
);

    typedef struct packed {
        logic                heavy_load_mode;
        logic                sample_strobe;
        logic [2:0]          threshold_select;
        logic                detect_latch;
        logic                sub_detect_flag;
        logic [IRQ_W-1:0]    irq_stat;
        logic [IRQ_W-1:0]    irq_mask;
        logic                irq;
        logic                det_en;
        logic [SETTLE_W-1:0] settle;
        logic                settled;
        logic                wr_pend;
        logic                rd_pend;
        logic [7:0]          addr;
        logic [31:0]         rdata;
        logic                ready;
    } state_s;

    localparam state_s RST = '{
        heavy_load_mode:  HLM_RST,
        sample_strobe:    STROBE_RST,
        threshold_select: THR_RST,
        detect_latch:     LATCH_RST,
        sub_detect_flag:  FLAG_RST,
        irq_mask:         MASK_RST,
        ready:            1'b1,
        default:          '0
    };

    state_s           s;
    state_s           n;
    logic             arm;
    logic             timer_busy;
    logic             timer_done;
    logic             sample_now;
    logic             sub_sample;
    logic [IRQ_W-1:0] events;

    instr_cycle_timer #(
        .CYCLES (INSTR_CLKS)
    ) u_timer (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .i_arm   (arm),
        .o_busy  (timer_busy),
        .o_done  (timer_done)
    );

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb
    begin
        n          = s;
        sample_now = 1'b0;
        sub_sample = 1'b0;
        events     = '0;

        // Hardware sampling points
        if (timer_done)
        begin
            sample_now = 1'b1;
            sub_sample = s.sub_detect_flag;
        end
        if (i_tick_2hz && (s.heavy_load_mode || s.sub_detect_flag))
        begin
            sample_now = 1'b1;
            sub_sample = sub_sample | s.sub_detect_flag;
        end

        // Register writes, data phase
        if (s.wr_pend)
        begin
            case (s.addr)
                OFF_CTRL:
                begin
                    n.heavy_load_mode  = i_hwdata[HLM_BIT];
                    n.sample_strobe    = i_hwdata[STROBE_BIT];
                    n.threshold_select = i_hwdata[THR_MSB:THR_LSB];
                    if (s.sample_strobe && !i_hwdata[STROBE_BIT])
                    begin
                        sample_now = 1'b1;
                    end
                end
                OFF_IRQ_STAT: n.irq_stat = s.irq_stat & ~i_hwdata[IRQ_W-1:0];
                OFF_IRQ_MASK: n.irq_mask = i_hwdata[IRQ_W-1:0];
                default:      n.irq_mask = s.irq_mask;
            endcase
        end

        // Sub-detector latches a low supply by itself
        if (!s.sub_detect_flag && i_sub_low)
        begin
            n.sub_detect_flag = 1'b1;
        end
        if (sub_sample)
        begin
            n.sub_detect_flag = i_sub_low;
        end
        if (sample_now)
        begin
            n.detect_latch = i_detect_result;
        end

        // Restart the one-cycle wait on either trigger rising
        arm = (n.heavy_load_mode && !s.heavy_load_mode)
            || (n.sub_detect_flag && !s.sub_detect_flag);

        // Set beats a simultaneous write-one clear
        events[IRQ_SAMPLE_BIT] = sample_now;
        events[IRQ_LOW_BIT]    = n.sub_detect_flag && !s.sub_detect_flag;
        n.irq_stat = n.irq_stat | events;
        n.irq      = |(n.irq_stat & n.irq_mask);

        // Detector power follows the triggers
        n.det_en = n.heavy_load_mode || n.sample_strobe
                 || n.sub_detect_flag;

        // On-time tracking; software must wait for settled
        if (!n.det_en)
        begin
            n.settle  = '0;
            n.settled = 1'b0;
        end
        else if (s.settle != SETTLE_W'(SETTLE_CLKS))
        begin
            n.settle  = s.settle + SETTLE_W'(1);
            n.settled = (n.settle == SETTLE_W'(SETTLE_CLKS));
        end

        // Bus: reads take one wait state so a write just
        // before is always visible
        n.wr_pend = 1'b0;
        n.ready   = 1'b1;
        if (s.rd_pend)
        begin
            n.rd_pend = 1'b0;
            case (s.addr)
                OFF_CTRL:
                    n.rdata = {25'h0, s.threshold_select, 2'h0,
                               s.sample_strobe, s.heavy_load_mode};
                OFF_STATUS:
                    n.rdata = {28'h0, s.settled, s.det_en,
                               s.sub_detect_flag, s.detect_latch};
                OFF_IRQ_STAT: n.rdata = {30'h0, s.irq_stat};
                OFF_IRQ_MASK: n.rdata = {30'h0, s.irq_mask};
                default:      n.rdata = 32'h0000_0000;
            endcase
        end
        if (i_hsel && i_htrans[1] && i_hready)
        begin
            n.addr = i_haddr[7:0];
            if (i_hwrite)
            begin
                n.wr_pend = 1'b1;
            end
            else
            begin
                n.rd_pend = 1'b1;
                n.ready   = 1'b0;
            end
        end
    end

    // ==========================================================
    // State register
    // ==========================================================
    // Clock enable low freezes the bus too; hreadyout holds its last value
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            s <= RST;
        end
        else if (i_ce)
        begin
            s <= n;
        end
    end

    assign o_hrdata           = s.rdata;
    assign o_hreadyout        = s.ready;
    assign o_hresp            = 1'b0;
    assign o_detect_enable    = s.det_en;
    assign o_threshold_select = s.threshold_select;
    assign o_irq              = s.irq;

    // ==========================================================
    // Checks
    // ==========================================================
    hlm_arm_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && !s.heavy_load_mode && n.heavy_load_mode) |=> timer_busy)
        else $error("heavy-load set did not arm the timer");

    hlm_tick_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && i_tick_2hz && s.heavy_load_mode)
        |=> (s.detect_latch == $past(i_detect_result)))
        else $error("2 Hz tick did not load the latch");

    strobe_load_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && s.wr_pend && s.addr == OFF_CTRL && s.sample_strobe
         && !i_hwdata[STROBE_BIT])
        |=> (s.detect_latch == $past(i_detect_result)))
        else $error("strobe clear did not load the latch");

    sub_first_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (timer_done && s.sub_detect_flag)
        |=> (s.sub_detect_flag == $past(i_sub_low))
            && (s.detect_latch == $past(i_detect_result)))
        else $error("sub flag sample missed a latch");

    sub_repeat_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(s.sub_detect_flag) |-> timer_busy ##0 o_detect_enable)
        else $error("sub flag did not restart sampling");

    read_latch_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && s.rd_pend && s.addr == OFF_STATUS)
        |=> o_hreadyout && (o_hrdata[LATCH_BIT] == $past(s.detect_latch)))
        else $error("status read lost the detect latch");

    reset_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(i_rst_n) |-> (!s.heavy_load_mode && !s.sub_detect_flag))
        else $error("control bits not cleared by reset");

    thr_out_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && s.wr_pend && s.addr == OFF_CTRL)
        |=> (o_threshold_select == $past(i_hwdata[THR_MSB:THR_LSB])))
        else $error("threshold select not taken from write");

    det_en_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_detect_enable == (s.heavy_load_mode || s.sample_strobe
                            || s.sub_detect_flag))
        else $error("detector enable does not follow triggers");

    irq_out_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && events[IRQ_SAMPLE_BIT] && n.irq_mask[IRQ_SAMPLE_BIT])
        |=> o_irq && s.irq_stat[IRQ_SAMPLE_BIT])
        else $error("unmasked sample event raised no interrupt");

endmodule // battery_level_sampling

// File: rtl/battery_level_pkg.sv
package battery_level_pkg;

    // ==========================================================
    // Register map, byte addresses
    // ==========================================================
    localparam logic [7:0] OFF_CTRL      = 8'h00;
    localparam logic [7:0] OFF_STATUS    = 8'h04;
    localparam logic [7:0] OFF_IRQ_STAT  = 8'h08;
    localparam logic [7:0] OFF_IRQ_MASK  = 8'h0C;

    // ==========================================================
    // Field positions
    // ==========================================================
    // Control register
    localparam int HLM_BIT    = 0;
    localparam int STROBE_BIT = 1;
    localparam int THR_LSB    = 4;
    localparam int THR_MSB    = 6;
    // Status register
    localparam int LATCH_BIT   = 0;
    localparam int FLAG_BIT    = 1;
    localparam int DET_EN_BIT  = 2;
    localparam int SETTLED_BIT = 3;
    // Interrupt status and mask
    localparam int IRQ_SAMPLE_BIT = 0;
    localparam int IRQ_LOW_BIT    = 1;
    localparam int IRQ_W          = 2;

    // ==========================================================
    // Values after reset
    // ==========================================================
    localparam logic             HLM_RST    = 1'b0;
    localparam logic             STROBE_RST = 1'b0;
    localparam logic             FLAG_RST   = 1'b0;
    localparam logic             LATCH_RST  = 1'b0;
    localparam logic [2:0]       THR_RST    = 3'h0;
    localparam logic [IRQ_W-1:0] MASK_RST   = 2'h0;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_PERIOD_NS = 25;
    // One processor instruction cycle, in system clocks
    localparam int INSTR_CYCLE_CLKS = 4;
    // Least detector on-time before a result is trusted
    localparam int SETTLE_TIME_NS = 100000;
    localparam int SETTLE_CLKS    =
        (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_W       = $clog2(SETTLE_CLKS + 1);

endpackage

// File: rtl/instr_cycle_timer.sv
`timescale 1ns/100ps

module instr_cycle_timer
    import battery_level_pkg::*;
#(
    parameter int CYCLES = INSTR_CYCLE_CLKS
)(
    // Clock, reset, enable
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_ce,
    // Control
    input  wire logic i_arm,
    output logic      o_busy,
    output logic      o_done
);

    localparam int CW = $clog2(CYCLES + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
    } state_s;

    state_s s;
    state_s n;

    // ==========================================================
    // Countdown of one instruction cycle
    // ==========================================================
    // Re-arming restarts the wait, so only the last set counts
    always_comb
    begin
        n = s;
        if (i_arm)
        begin
            n.cnt = CW'(CYCLES);
        end
        else if (s.cnt != '0)
        begin
            n.cnt = s.cnt - CW'(1);
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            s <= '0;
        end
        else if (i_ce)
        begin
            s <= n;
        end
    end

    assign o_busy = (s.cnt != '0);
    assign o_done = (s.cnt == CW'(1)) && i_ce && !i_arm;

endmodule // instr_cycle_timer

// File: tb/battery_level_sampling_tb_top.sv
`timescale 1ns/100ps

module battery_level_sampling_tb_top;
    import battery_level_pkg::*;

    // Short instruction cycle keeps the first-sample window easy to hit
    localparam int INSTR = 4;

    // ==========================================================
    // Signals
    // ==========================================================
    logic        clk;
    logic        rst_n;
    logic        ce;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        tick;
    logic        result;
    logic        sub_low;
    logic        det_en;
    logic [2:0]  thr;
    logic        irq;
    logic [31:0] rd;
    int          n_fail;
    int          total_checks;

    battery_level_sampling #(
        .INSTR_CLKS (INSTR)
    ) battery_level_sampling_inst (
        .i_clk              (clk),
        .i_rst_n            (rst_n),
        .i_ce               (ce),
        .i_hsel             (1'b1),
        .i_haddr            (haddr),
        .i_htrans           (htrans),
        .i_hwrite           (hwrite),
        .i_hsize            (3'b010),
        .i_hwdata           (hwdata),
        .i_hready           (hreadyout),
        .o_hrdata           (hrdata),
        .o_hreadyout        (hreadyout),
        .o_hresp            (hresp),
        .i_tick_2hz         (tick),
        .i_detect_result    (result),
        .i_sub_low          (sub_low),
        .o_detect_enable    (det_en),
        .o_threshold_select (thr),
        .o_irq              (irq)
    );

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic check_val(input logic [31:0] got,
                             input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    // One single-word transfer; waits on hready, never a fixed count
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        htrans <= 2'b10;
        haddr  <= {24'h00_0000, a};
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        check_val(rd, exp);
    endtask

    task automatic tick_pulse;
        @(posedge clk);
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
    endtask

    task automatic report_and_stop;
        if (n_fail == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Longest test is the settle wait of about 4000 clocks
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial
    begin
        rst_n = 1'b0;
        ce = 1'b1;
        htrans = 2'b00;
        haddr = 32'h0000_0000;
        hwrite = 1'b0;
        hwdata = 32'h0000_0000;
        tick = 1'b0;
        result = 1'b0;
        sub_low = 1'b0;
        n_fail = 0;
        total_checks = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        check_val({27'h000_0000, irq, det_en, thr}, 32'h0000_0000);
        rd_chk(OFF_CTRL, 32'h0000_0000);
        rd_chk(OFF_STATUS, 32'h0000_0000);
        rd_chk(OFF_IRQ_MASK, 32'h0000_0000);
        for (int t = 0; t < 8; t++)
        begin
            bus(1'b1, OFF_CTRL, 32'(t) << THR_LSB);
            rd_chk(OFF_CTRL, 32'(t) << THR_LSB);
            check_val({29'h0000_0000, thr}, 32'(t));
        end
        bus(1'b1, OFF_CTRL, 32'h0000_0000);
        // Result high only at the exact first-sample edge
        bus(1'b1, OFF_CTRL, 32'h0000_0001);
        repeat (INSTR - 1) @(posedge clk);
        result <= 1'b1;
        @(posedge clk);
        result <= 1'b0;
        rd_chk(OFF_STATUS, 32'h0000_0005);
        check_val({31'h0000_0000, det_en}, 32'h0000_0001);
        tick_pulse();
        rd_chk(OFF_STATUS, 32'h0000_0004);
        bus(1'b1, OFF_CTRL, 32'h0000_0000);
        result <= 1'b1;
        tick_pulse();
        rd_chk(OFF_STATUS, 32'h0000_0000);
        result <= 1'b0;
        sub_low <= 1'b1;
        repeat (INSTR) @(posedge clk);
        result <= 1'b1;
        @(posedge clk);
        result <= 1'b0;
        rd_chk(OFF_STATUS, 32'h0000_0007);
        tick_pulse();
        rd_chk(OFF_STATUS, 32'h0000_0006);
        sub_low <= 1'b0;
        tick_pulse();
        rd_chk(OFF_STATUS, 32'h0000_0000);
        check_val({31'h0000_0000, det_en}, 32'h0000_0000);
        // Enable low: a tick during the freeze must not sample
        bus(1'b1, OFF_CTRL, 32'h0000_0001);
        repeat (INSTR + 2) @(posedge clk);
        ce <= 1'b0;
        result <= 1'b1;
        tick_pulse();
        ce <= 1'b1;
        rd_chk(OFF_STATUS, 32'h0000_0004);
        result <= 1'b0;
        bus(1'b1, OFF_CTRL, 32'h0000_0000);
        result <= 1'b1;
        bus(1'b1, OFF_CTRL, 32'h0000_0002);
        // Fast bench clock, so the strobe hold is counted out
        repeat (SETTLE_CLKS - 8) @(posedge clk);
        rd_chk(OFF_STATUS, 32'h0000_0004);
        repeat (4) @(posedge clk);
        rd_chk(OFF_STATUS, 32'h0000_000C);
        bus(1'b1, OFF_CTRL, 32'h0000_0000);
        rd_chk(OFF_STATUS, 32'h0000_0001);
        result <= 1'b0;
        bus(1'b1, OFF_CTRL, 32'h0000_0000);
        rd_chk(OFF_STATUS, 32'h0000_0001);
        rd_chk(OFF_IRQ_STAT, 32'h0000_0003);
        check_val({31'h0000_0000, irq}, 32'h0000_0000);
        bus(1'b1, OFF_IRQ_MASK, 32'h0000_0002);
        rd_chk(OFF_IRQ_MASK, 32'h0000_0002);
        check_val({31'h0000_0000, irq}, 32'h0000_0001);
        bus(1'b1, OFF_IRQ_STAT, 32'h0000_0002);
        rd_chk(OFF_IRQ_STAT, 32'h0000_0001);
        check_val({31'h0000_0000, irq}, 32'h0000_0000);
        bus(1'b1, OFF_IRQ_MASK, 32'h0000_0003);
        rd_chk(OFF_IRQ_MASK, 32'h0000_0003);
        check_val({31'h0000_0000, irq}, 32'h0000_0001);
        bus(1'b1, OFF_IRQ_STAT, 32'h0000_0001);
        rd_chk(OFF_IRQ_STAT, 32'h0000_0000);
        check_val({31'h0000_0000, irq}, 32'h0000_0000);
        // Unmasked sample event raises the interrupt
        bus(1'b1, OFF_CTRL, 32'h0000_0002);
        bus(1'b1, OFF_CTRL, 32'h0000_0000);
        rd_chk(OFF_IRQ_STAT, 32'h0000_0001);
        check_val({31'h0000_0000, irq}, 32'h0000_0001);
        bus(1'b1, OFF_IRQ_STAT, 32'h0000_0001);
        rd_chk(OFF_IRQ_STAT, 32'h0000_0000);
        check_val({31'h0000_0000, irq}, 32'h0000_0000);
        // Unmapped place: reads zero, write has no effect
        bus(1'b1, 8'h10, 32'hFFFF_FFFF);
        rd_chk(8'h10, 32'h0000_0000);
        rd_chk(OFF_CTRL, 32'h0000_0000);
        check_val({31'h0000_0000, hresp}, 32'h0000_0000);
        report_and_stop();
    end

endmodule // battery_level_sampling_tb_top
